//--- src/pvic_ctrl.sv
// Purpose: prioritised vectored interrupt controller, top level
// Assumes: execution unit finishes its instruction before acking
// Notes:   peripheral requests are one-cycle set pulses
//
// Function
// R1: requests latch into pending flags until cleared
// R2: unit finishes instruction, saves PC, loads vector
// R3: return clears in-progress level marker
// R4: two-bit priority, high bit upper, 3 highest
// R5: preempt only by strictly higher level
// R6: highest pending level serviced first
// R7: same level chosen by fixed polling order
// R8: vector is 0003h plus eight times slot
// R9: pin level low or falling edge by type
// R10: pin event sets flag, forwarded when enabled
// R11: edge flag cleared on vectoring
// R12: level source released, flag cleared by software
// R13: low pin level wakes from power-down
// R14: pins sampled once per six clocks
// R15: level request held over six clocks
// R16: edge request held low six clocks
// R17: every source enabled individually, any time
// R18: two enable, four priority 8-bit registers
// R19: global enable bit 7 gates everything
// R20: pins synchronised, edges between consecutive samples
// R21: reserved slots never request or vector
`timescale 1ns/1ps
module pvic_ctrl (
  // clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_resetn,
  // register images
  input  wire pvic_pkg::pvic_cfg_t  i_cfg,
  input  wire logic                 i_trig_type_a,
  input  wire logic                 i_trig_type_b,
  // pins
  input  wire logic                 i_ext_irq_pin_a_n,
  input  wire logic                 i_ext_irq_pin_b_n,
  input  wire logic                 i_keypad_irq_in,
  // peripheral requests and software clears
  input  wire logic [14:0]          i_periph_set,
  input  wire logic [14:0]          i_sw_clr,
  // execution unit handshake
  input  wire logic                 i_irq_ack,
  input  wire logic                 i_return_from_irq_instr,
  // outputs
  output pvic_pkg::pvic_req_t       o_req,
  output logic [14:0]               o_pending,
  output logic [3:0]                o_inprog,
  output logic                      o_keypad_sample,
  output logic                      o_wake
);

  // ****************************************************************
  // peripheral cycle divider
  // ****************************************************************
  logic [2:0] pcyc_cnt_r;
  logic       samp_en;

  // six-clock sample enable pulse
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pcyc_cnt_r <= 3'h0;
    end else if (samp_en) begin
      pcyc_cnt_r <= 3'h0;
    end else begin
      pcyc_cnt_r <= pcyc_cnt_r + 3'h1;
    end
  end
  assign samp_en = (pcyc_cnt_r == 3'(pvic_pkg::PCYC_CLKS - 1)); // R14

  // keyboard input sampled on the same enable
  logic kp_s1_r;
  logic kp_s2_r;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      kp_s1_r         <= 1'b1;
      kp_s2_r         <= 1'b1;
      o_keypad_sample <= 1'b1;
    end else begin
      kp_s1_r <= i_keypad_irq_in;
      kp_s2_r <= kp_s1_r;
      if (samp_en) begin
        o_keypad_sample <= kp_s2_r; // R14
      end
    end
  end

  // ****************************************************************
  // external pins
  // ****************************************************************
  logic        flag_a;
  logic        flag_b;
  logic        low_a;
  logic        low_b;
  logic        hw_clr_a;
  logic        hw_clr_b;
  logic        taking;

  pvic_ext_pin u_pin_a (
    .i_mclk          (i_mclk),
    .i_resetn        (i_resetn),
    .i_pin_n         (i_ext_irq_pin_a_n),
    .i_samp_en       (samp_en),
    .i_trig_type_sel (i_trig_type_a),
    .i_sw_clr        (i_sw_clr[pvic_pkg::SLOT_EXT_A]),
    .i_hw_clr        (hw_clr_a),
    .o_ext_req_flag  (flag_a),
    .o_low_level     (low_a)
  );

  pvic_ext_pin u_pin_b (
    .i_mclk          (i_mclk),
    .i_resetn        (i_resetn),
    .i_pin_n         (i_ext_irq_pin_b_n),
    .i_samp_en       (samp_en),
    .i_trig_type_sel (i_trig_type_b),
    .i_sw_clr        (i_sw_clr[pvic_pkg::SLOT_EXT_B]),
    .i_hw_clr        (hw_clr_b),
    .o_ext_req_flag  (flag_b),
    .o_low_level     (low_b)
  );

  assign o_wake = low_a | low_b; // R13

  // ****************************************************************
  // pending flags
  // ****************************************************************
  logic [14:0] pend_r;
  logic [14:0] ack_clr;

  // latch peripheral pulses; set wins over clear
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_r <= pvic_pkg::PEND_RST;
    end else begin
      pend_r <= ((pend_r & ~i_sw_clr & ~ack_clr) | i_periph_set) // R1
              & ~pvic_pkg::SLOT_RSVD_MASK;                        // R21
    end
  end

  // external flags replace their pending slots
  logic [14:0] pend_all;
  always_comb begin
    pend_all = pend_r;
    pend_all[pvic_pkg::SLOT_EXT_A] = flag_a; // R10
    pend_all[pvic_pkg::SLOT_EXT_B] = flag_b; // R10
  end
  assign o_pending = pend_all;

  // ****************************************************************
  // enables and priority levels
  // ****************************************************************
  logic [15:0] en_vec;
  logic [15:0] ph_vec;
  logic [15:0] pl_vec;
  logic [14:0] armed;
  assign en_vec = {1'b0, i_cfg.en_hi, i_cfg.en_lo[6:0]};    // R18
  assign ph_vec = {1'b0, i_cfg.ph_b, i_cfg.ph_a[6:0]};
  assign pl_vec = {1'b0, i_cfg.pl_b, i_cfg.pl_a[6:0]};
  // slots 0..6 from the low register, 7..14 from the high one
  assign armed = pend_all & en_vec[14:0]                     // R17
               & ~pvic_pkg::SLOT_RSVD_MASK                   // R21
               & {15{i_cfg.en_lo[pvic_pkg::EN_GLOBAL_BIT]}}; // R19

  // ****************************************************************
  // arbitration
  // ****************************************************************
  logic       win_valid;
  logic [3:0] win_slot;
  logic [1:0] win_lvl;
  logic [1:0] lvl;

  // highest level first, lowest slot on ties
  always_comb begin
    win_valid = 1'b0;
    win_slot  = 4'h0;
    win_lvl   = 2'h0;
    lvl       = 2'h0;
    for (int i = 0; i < pvic_pkg::NUM_SLOTS; i++) begin
      lvl = {ph_vec[i], pl_vec[i]}; // R4
      if (armed[i] && (!win_valid || lvl > win_lvl)) begin // R6 R7
        win_valid = 1'b1;
        win_slot  = 4'(i);
        win_lvl   = lvl;
      end
    end
  end

  // preemption only by a strictly higher level
  logic [3:0] inprog_r;
  logic       allowed;
  always_comb begin
    allowed = 1'b1;
    for (int l = 0; l < 4; l++) begin
      if (inprog_r[l] && 2'(l) >= win_lvl) begin
        allowed = 1'b0; // R5
      end
    end
  end

  // ****************************************************************
  // request handshake
  // ****************************************************************
  pvic_pkg::pvic_state_t state_r;
  assign taking = (state_r == pvic_pkg::PVIC_REQ) && i_irq_ack;

  // present winner, hold until execution unit acks
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= pvic_pkg::PVIC_IDLE;
      o_req   <= '0;
    end else begin
      case (state_r)
        pvic_pkg::PVIC_IDLE: begin
          if (win_valid && allowed) begin
            state_r      <= pvic_pkg::PVIC_REQ;
            o_req.valid  <= 1'b1;
            o_req.slot   <= win_slot;
            o_req.level  <= win_lvl;
            o_req.vector <= pvic_pkg::VEC_BASE
              + (16'(win_slot) << pvic_pkg::VEC_SHIFT); // R8
          end
        end
        pvic_pkg::PVIC_REQ: begin
          if (i_irq_ack) begin // R2
            state_r     <= pvic_pkg::PVIC_ACK;
            o_req.valid <= 1'b0;
          end
        end
        pvic_pkg::PVIC_ACK: begin
          state_r <= pvic_pkg::PVIC_IDLE;
        end
        default: begin
          state_r <= pvic_pkg::PVIC_IDLE;
        end
      endcase
    end
  end

  // vectoring clears the taken source's flag, except a level-type pin's
  always_comb begin
    ack_clr = '0;
    if (taking) begin
      ack_clr[o_req.slot] = 1'b1;
    end
  end
  assign hw_clr_a = taking && (o_req.slot == pvic_pkg::SLOT_EXT_A); // R11
  assign hw_clr_b = taking && (o_req.slot == pvic_pkg::SLOT_EXT_B); // R11

  // in-progress markers: set on ack, cleared on return
  logic [3:0] top_bit;
  always_comb begin
    top_bit = 4'h0;
    for (int l = 0; l < 4; l++) begin
      if (inprog_r[l]) begin
        top_bit = 4'h0;
        top_bit[l] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      inprog_r <= pvic_pkg::INPROG_RST;
    end else begin
      inprog_r <= (inprog_r
                   & ~({4{i_return_from_irq_instr}} & top_bit)) // R3
                | ({4{taking}} & (4'h1 << o_req.level));        // R2
    end
  end
  assign o_inprog = inprog_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_vector_formula: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_req.valid |-> o_req.vector == 16'h0003 + {9'h0, o_req.slot, 3'h0}) // R8
    else $error("vector address wrong");
  a_sample_period: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    samp_en |=> !samp_en [*5] ##1 samp_en) // R14
    else $error("sample enable period not six");
  a_no_reserved: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_req.valid |-> !pvic_pkg::SLOT_RSVD_MASK[o_req.slot]) // R21
    else $error("reserved slot vectored");
  a_global_gate: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(o_req.valid) |-> $past(i_cfg.en_lo[7])) // R19
    else $error("request without global enable");
  a_preempt_higher: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(o_req.valid) |-> ($past(inprog_r) >> o_req.level) == 4'h0) // R5
    else $error("preemption by equal or lower level");
  a_ack_marks: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    taking |=> inprog_r[$past(o_req.level)]) // R2
    else $error("in-progress marker not set");
  a_return_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (i_return_from_irq_instr && !taking && inprog_r[3]) |=> !inprog_r[3]) // R3
    else $error("return did not clear top level");
  a_pend_latch: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_periph_set[3] |=> pend_r[3]) // R1
    else $error("request not latched");

endmodule // pvic_ctrl

//--- src/pvic_ext_pin.sv
// Purpose: one external request pin: synchroniser, sampler, request flag
// Assumes: sample enable pulses once every six clocks
// Notes:   pin is active low
`timescale 1ns/1ps
module pvic_ext_pin (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  // pin and control
  input  wire logic i_pin_n,
  input  wire logic i_samp_en,
  input  wire logic i_trig_type_sel,
  input  wire logic i_sw_clr,
  input  wire logic i_hw_clr,
  // status
  output logic      o_ext_req_flag,
  output logic      o_low_level
);

  logic sync1_r;
  logic sync2_r;
  logic samp_r;
  logic samp_prev_r;
  logic samp_dly_r;
  logic event_w;

  // two flop synchroniser
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= i_pin_n;        // R20
      sync2_r <= sync1_r;
    end
  end

  // sample once per peripheral cycle; mark the cycle after a sample
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      samp_r      <= 1'b1;
      samp_prev_r <= 1'b1;
      samp_dly_r  <= 1'b0;
    end else begin
      samp_dly_r <= i_samp_en;
      if (i_samp_en) begin
        samp_r      <= sync2_r;  // R14
        samp_prev_r <= samp_r;   // R20
      end
    end
  end

  // one-cycle event per sample so a vectoring clear is not undone
  assign event_w = samp_dly_r
                 & ((i_trig_type_sel == pvic_pkg::TRIG_EDGE)
                    ? (samp_prev_r & ~samp_r) // R9
                    : ~samp_r);               // R9

  // request flag, set wins over clear
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ext_req_flag <= 1'b0;
    end else if (event_w) begin
      o_ext_req_flag <= 1'b1;  // R10
    end else if (i_sw_clr) begin
      o_ext_req_flag <= 1'b0;
    end else if (i_hw_clr && i_trig_type_sel == pvic_pkg::TRIG_EDGE) begin
      o_ext_req_flag <= 1'b0;  // R11
    end
  end

  assign o_low_level = ~sync2_r;  // R13

endmodule // pvic_ext_pin

//--- src/pvic_pkg.sv
// Purpose: shared constants and types for the vectored interrupt controller
// Assumes: one 200 MHz clock; peripheral cycle of six clocks
// Notes:   enable and priority register images are 8-bit fields of one struct port
package pvic_pkg;

  // ****************************************************************
  // sizes and slots
  // ****************************************************************
  localparam int unsigned NUM_SLOTS  = 15;
  localparam int unsigned SLOT_W     = 4;
  localparam int unsigned PRIO_W     = 2;
  localparam int unsigned VEC_W      = 16;
  localparam int unsigned PCYC_CLKS  = 6;   // clocks per peripheral cycle
  localparam int unsigned PCYC_W     = 3;

  // slot numbers in polling order
  localparam logic [3:0] SLOT_EXT_A = 4'h0;
  localparam logic [3:0] SLOT_EXT_B = 4'h2;
  localparam logic [3:0] SLOT_KEYPD = 4'hB;
  localparam logic [14:0] SLOT_RSVD_MASK = 15'h5400; // slots 10,12,14

  // vector address: base plus slot times stride
  localparam logic [15:0] VEC_BASE   = 16'h0003;
  localparam int unsigned VEC_SHIFT  = 3;   // stride of eight

  // enable register bit positions
  localparam int unsigned EN_GLOBAL_BIT = 7;
  localparam int unsigned EN_EXT_A_BIT  = 0;
  localparam int unsigned EN_EXT_B_BIT  = 2;

  // trigger type encodings
  localparam logic TRIG_LEVEL = 1'b0;
  localparam logic TRIG_EDGE  = 1'b1;

  // reset values
  localparam logic [14:0] PEND_RST   = 15'h0000;
  localparam logic [3:0]  INPROG_RST = 4'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] en_lo;   // global enable plus first sources
    logic [7:0] en_hi;
    logic [7:0] ph_a;
    logic [7:0] pl_a;
    logic [7:0] ph_b;
    logic [7:0] pl_b;
  } pvic_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  slot;
    logic [1:0]  level;
    logic [15:0] vector;
  } pvic_req_t;

  typedef enum logic [1:0] {
    PVIC_IDLE = 2'b00,
    PVIC_REQ  = 2'b01,
    PVIC_ACK  = 2'b11
  } pvic_state_t;

endpackage

//--- verification/prioritized_vectored_irq_ctrl_tb.sv
// Purpose: self-checking bench for the vectored interrupt controller
// Assumes: 200 MHz clock, model acks requests
// Notes:   tests are sequences of pulse, serve and return calls
`timescale 1ns/1ps
module prioritized_vectored_irq_ctrl_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                i_mclk;
  logic                i_resetn;
  pvic_pkg::pvic_cfg_t cfg;
  logic                trig_type_a;
  logic                trig_type_b;
  logic                pin_a_n;
  logic                pin_b_n;
  logic                keypad_irq_in;
  logic [14:0]         set;
  logic [14:0]         clr;
  logic                ack;
  logic                ret_pulse;
  logic [3:0]          lat;
  pvic_pkg::pvic_req_t o_req;
  logic [14:0]         o_pending;
  logic [3:0]          o_inprog;
  logic                o_keypad_sample;
  logic                o_wake;
  int                  num_errors;
  int                  tests_run;
  int                  cyc;
  localparam logic [3:0] SLOTS [10] =
    '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB, 4'hD};

  pvic_ctrl u_pvic_ctrl (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_cfg(cfg),
    .i_trig_type_a(trig_type_a), .i_trig_type_b(trig_type_b),
    .i_ext_irq_pin_a_n(pin_a_n), .i_ext_irq_pin_b_n(pin_b_n),
    .i_keypad_irq_in(keypad_irq_in), .i_periph_set(set),
    .i_sw_clr(clr), .i_irq_ack(ack),
    .i_return_from_irq_instr(ret_pulse), .o_req(o_req),
    .o_pending(o_pending), .o_inprog(o_inprog),
    .o_keypad_sample(o_keypad_sample), .o_wake(o_wake));

  pvic_exec_model u_pvic_exec_model (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_req(o_req),
    .i_lat(lat), .o_irq_ack(ack));

  // ****************************************************************
  // tasks
  // ****************************************************************
  // compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      num_errors++;
    end
  endtask

  // verdict and end of run
  task results();
    $display("errors=%0d compares=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // settle after some edges
  task idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // one-cycle peripheral set pulses
  task pset(input logic [14:0] m);
    @(posedge i_mclk);
    set <= m;
    @(posedge i_mclk);
    set <= 15'h0000;
  endtask

  // program one slot's two-bit level
  task lvl(input logic [3:0] s, input logic [1:0] l);
    if (s < 4'h7) begin
      cfg.ph_a[s] <= l[1];
      cfg.pl_a[s] <= l[0];
    end else begin
      cfg.ph_b[s - 4'h7] <= l[1];
      cfg.pl_b[s - 4'h7] <= l[0];
    end
  endtask

  // wait for request, check it, wait until taken
  task serve(input logic [3:0] s, input logic [1:0] l);
    int i;
    for (i = 0; i < 40; i++) begin
      idle(1);
      if (o_req.valid === 1'b1) break;
    end
    chk(o_req.valid, 1'b1);
    chk(o_req.slot, s);
    chk(o_req.level, l);
    chk(o_req.vector, 16'h0003 + {s, 3'b000});
    for (i = 0; i < 30; i++) begin
      idle(1);
      if (o_req.valid === 1'b0) break;
    end
    chk(o_inprog[l], 1'b1);
  endtask

  // return instruction pulse
  task ret();
    @(posedge i_mclk);
    ret_pulse <= 1'b1;
    @(posedge i_mclk);
    ret_pulse <= 1'b0;
    idle(1);
  endtask

  // ****************************************************************
  // clock, timeout and tests
  // ****************************************************************
  // free running clock
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      results();
    end
  end

  // main sequence
  initial begin
    cfg = {8'hFF, 8'hFF, 32'h0};
    trig_type_a = 1'b1;
    trig_type_b = 1'b0;
    pin_a_n = 1'b1;
    pin_b_n = 1'b1;
    keypad_irq_in = 1'b1;
    set = 15'h0000;
    clr = 15'h0000;
    ret_pulse = 1'b0;
    lat = 4'h0;
    i_resetn = 1'b0;
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    idle(1);
    chk(o_pending, 15'h0000);
    chk(o_inprog, 4'h0);
    chk(o_keypad_sample, 1'b1);
    chk(o_wake, 1'b0);
    // every internal slot vectors, prompt and slow answers
    foreach (SLOTS[i]) begin
      lat <= 4'(i);
      pset(15'h0001 << SLOTS[i]);
      serve(SLOTS[i], 2'h0);
      ret();
      chk(o_inprog, 4'h0);
    end
    // same level: polling order, loser stays pending
    pset(15'h0210);
    serve(4'h4, 2'h0);
    chk(o_pending[9], 1'b1);
    ret();
    serve(4'h9, 2'h0);
    ret();
    // different levels together
    lvl(4'hD, 2'h3);
    lvl(4'h1, 2'h1);
    pset(15'h2002);
    serve(4'hD, 2'h3);
    ret();
    serve(4'h1, 2'h1);
    ret();
    // equal level waits, higher level preempts
    lvl(4'h3, 2'h2);
    lvl(4'h5, 2'h2);
    pset(15'h0008);
    serve(4'h3, 2'h2);
    pset(15'h0020);
    idle(20);
    chk(o_req.valid, 1'b0);
    pset(15'h2000);
    serve(4'hD, 2'h3);
    ret();
    chk(o_inprog, 4'h4);
    idle(10);
    chk(o_req.valid, 1'b0);
    ret();
    serve(4'h5, 2'h2);
    ret();
    // global gate and individual enable
    cfg.en_lo[7] <= 1'b0;
    pset(15'h0040);
    idle(20);
    chk(o_req.valid, 1'b0);
    chk(o_pending[6], 1'b1);
    cfg.en_lo <= 8'hBF;
    idle(20);
    chk(o_req.valid, 1'b0);
    cfg.en_lo <= 8'hFF;
    serve(4'h6, 2'h0);
    ret();
    // reserved slots never request
    pset(15'h5400);
    idle(20);
    chk(o_pending, 15'h0000);
    chk(o_req.valid, 1'b0);
    // falling edge on pin a, held thirteen clocks
    lat <= 4'hF;
    @(posedge i_mclk);
    pin_a_n <= 1'b0;
    idle(4);
    chk(o_wake, 1'b1);
    idle(8);
    @(posedge i_mclk);
    pin_a_n <= 1'b1;
    serve(4'h0, 2'h0);
    chk(o_pending[0], 1'b0);
    ret();
    // low level on pin b, masked then enabled
    cfg.en_lo <= 8'hFB;
    @(posedge i_mclk);
    pin_b_n <= 1'b0;
    idle(14);
    chk(o_pending[2], 1'b1);
    chk(o_req.valid, 1'b0);
    cfg.en_lo <= 8'hFF;
    serve(4'h2, 2'h0);
    @(posedge i_mclk);
    pin_b_n <= 1'b1;
    idle(10);
    @(posedge i_mclk);
    clr <= 15'h0004;
    @(posedge i_mclk);
    clr <= 15'h0000;
    idle(2);
    chk(o_pending[2], 1'b0);
    ret();
    // keypad input sampling
    @(posedge i_mclk);
    keypad_irq_in <= 1'b0;
    idle(10);
    chk(o_keypad_sample, 1'b0);
    results();
  end
endmodule // prioritized_vectored_irq_ctrl_tb

//--- verification/pvic_exec_model.sv
// Purpose: execution unit model that takes controller requests
// Assumes: a request stands until the cycle after it is taken
// Notes:   latency in cycles is set by the bench
`timescale 1ns/1ps
module pvic_exec_model (
  // clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_resetn,
  // request side
  input  wire pvic_pkg::pvic_req_t i_req,
  input  wire logic [3:0]          i_lat,
  // answer
  output logic                     o_irq_ack
);
  // ****************************************************************
  // acknowledge once the running instruction has finished
  // ****************************************************************
  logic [3:0] wait_r;

  // count latency, then one ack pulse while the request stands
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_r    <= 4'h0;
      o_irq_ack <= 1'b0;
    end else if (o_irq_ack) begin
      o_irq_ack <= 1'b0;
      wait_r    <= 4'h0;
    end else if (i_req.valid) begin
      if (wait_r == i_lat) o_irq_ack <= 1'b1;
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // pvic_exec_model
